/* File: core/sram_map.vh */
// Constants for the burst SRAM write, address and read capture block
`ifndef SRAM_MAP_VH
`define SRAM_MAP_VH

// Width modes
`define MODE_W8 2'h0
`define MODE_W9 2'h1
`define MODE_W18 2'h2
`define MODE_W36 2'h3

// Address widths per mode
`define ADDR_BITS_W8 20
`define ADDR_BITS_W18 19
`define ADDR_BITS_W36 18
`define ADDR_MASK_W36 20'h3FFFF
`define ADDR_MASK_W18 20'h7FFFF
`define ADDR_MASK_W8 20'hFFFFF

// Storage shape
`define DATA_BITS 36
`define LANE_BITS 9
`define BANKS 4
`define FIFO_DEPTH 8
`define FIFO_ADDR_BITS 3
`define ENTRY_BITS 92

// Pin bundle bit positions
`define PIN_K 0
`define PIN_KN 1
`define PIN_C 2
`define PIN_CN 3
`define PIN_WSEL 4
`define PIN_RSEL 5
`define PIN_NLO 6
`define PIN_NHI 7
`define PIN_LANE 8
`define PIN_ADDR 12
`define PIN_DATA 32
`define PIN_MODE 68
`define PIN_SCM 70
`define PIN_BITS 71
// Selects and masks idle high; complementary clocks idle high
`define PIN_RST 71'h0FFA

`endif

/* File: core/sram_quad_array.v */
// Four equal storage arrays with bit-masked write and registered read
`timescale 1ns/1ps
module sram_quad_array #(
  parameter AW = 18,
  parameter DW = 36
) (
  input wire clk,
  input wire wr_en,
  input wire [1:0] wr_bank,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [DW-1:0] wr_mask,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output wire [4*DW-1:0] rd_data
);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : bank
      reg [DW-1:0] mem [0:(1<<AW)-1];
      reg [DW-1:0] rd_q;
      // Unmasked bits keep their stored value
      always @(posedge clk) begin
        if (wr_en && wr_bank == g) begin
          mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
        end
        if (rd_en) begin
          rd_q <= mem[rd_addr];
        end
      end
      assign rd_data[g*DW +: DW] = rd_q;
    end
  endgenerate

endmodule // sram_quad_array

/* File: core/sram_write_and_address_capture.v */
// Burst SRAM input capture: write beats, masks, address, read bursts
`timescale 1ns/1ps
`include "sram_map.vh"
module sram_write_and_address_capture (
  input wire clk,
  input wire sys_rst,
  input wire k_in,
  input wire k_n_in,
  input wire c_in,
  input wire c_n_in,
  input wire write_port_select_n,
  input wire read_port_select_n,
  input wire nibble_mask_lo_n,
  input wire nibble_mask_hi_n,
  input wire lane_mask0_n,
  input wire lane_mask1_n,
  input wire lane_mask2_n,
  input wire lane_mask3_n,
  input wire [19:0] addr_in,
  input wire [35:0] data_in,
  input wire [1:0] width_mode,
  input wire single_clock_mode,
  output reg [35:0] q_out,
  output reg q_oe,
  output reg write_stall,
  output reg write_overflow
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [`PIN_BITS-1:0] pins;
  reg [`PIN_BITS-1:0] s1_r;
  reg [`PIN_BITS-1:0] s2_r;
  reg [`PIN_BITS-1:0] s3_r;
  reg [`PIN_BITS-1:0] pin_r;
  localparam [`PIN_BITS-1:0] pin_idle = `PIN_RST;

  assign pins = {single_clock_mode, width_mode, data_in, addr_in,
                 lane_mask3_n, lane_mask2_n, lane_mask1_n, lane_mask0_n,
                 nibble_mask_hi_n, nibble_mask_lo_n, read_port_select_n,
                 write_port_select_n, c_n_in, c_in, k_n_in, k_in};

  genvar i;
  generate
    for (i = 0; i < `PIN_BITS; i = i + 1) begin : sync
      // Value only counts once stages two and three agree
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_r[i] <= pin_idle[i];
          s2_r[i] <= pin_idle[i];
          s3_r[i] <= pin_idle[i];
          pin_r[i] <= pin_idle[i];
        end else begin
          s1_r[i] <= pins[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            pin_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  wire [1:0] mode;
  wire scm;
  wire [35:0] din;
  wire [3:0] lane_en;
  wire [1:0] nib_en;
  reg [19:0] addr_eff;
  reg [3:0] clk_prev_r;
  wire k_rise;
  wire kn_rise;
  wire oc_rise;
  wire ocn_rise;

  assign mode = pin_r[`PIN_MODE +: 2];
  assign scm = pin_r[`PIN_SCM];
  assign din = pin_r[`PIN_DATA +: 36];
  assign lane_en = ~pin_r[`PIN_LANE +: 4];
  assign nib_en = ~pin_r[`PIN_NHI:`PIN_NLO];

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_prev_r <= pin_idle[`PIN_CN:`PIN_K];
    end else begin
      clk_prev_r <= pin_r[`PIN_CN:`PIN_K];
    end
  end

  assign k_rise = pin_r[`PIN_K] & ~clk_prev_r[0];
  assign kn_rise = pin_r[`PIN_KN] & ~clk_prev_r[1];
  // Output clock pair, or input pair in single clock mode
  assign oc_rise = scm ? k_rise : (pin_r[`PIN_C] & ~clk_prev_r[2]);
  assign ocn_rise = scm ? kn_rise : (pin_r[`PIN_CN] & ~clk_prev_r[3]);

  // Upper address bits beyond the mode's width are dropped
  always @* begin
    case (mode)
      `MODE_W36: addr_eff = pin_r[`PIN_ADDR +: 20] & `ADDR_MASK_W36;
      `MODE_W18: addr_eff = pin_r[`PIN_ADDR +: 20] & `ADDR_MASK_W18;
      default: addr_eff = pin_r[`PIN_ADDR +: 20] & `ADDR_MASK_W8;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Address split: word index within an array and narrow lane select
  function [19:0] word_of;
    input [1:0] m;
    input [19:0] a;
    begin
      case (m)
        `MODE_W36: word_of = {2'h0, a[17:0]};
        `MODE_W18: word_of = {2'h0, a[18:1]};
        default: word_of = {2'h0, a[19:2]};
      endcase
    end
  endfunction

  function [1:0] sub_of;
    input [1:0] m;
    input [19:0] a;
    begin
      case (m)
        `MODE_W36: sub_of = 2'h0;
        `MODE_W18: sub_of = {a[0], 1'b0};
        default: sub_of = a[1:0];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Write burst sequencing
  reg wr_busy_r;
  reg [1:0] wr_beat_r;
  reg pend_v_r;
  reg [19:0] pend_a_r;
  reg [19:0] wr_a_r;
  reg beat_fire;
  reg [1:0] beat_idx;
  reg [19:0] beat_addr;
  wire start_burst;

  assign start_burst = k_rise & ~wr_busy_r & pend_v_r;

  always @* begin
    beat_fire = 1'b0;
    beat_idx = wr_beat_r;
    beat_addr = wr_a_r;
    if (start_burst) begin
      beat_fire = 1'b1;
      beat_idx = 2'h0;
      beat_addr = pend_a_r;
    end else if (k_rise && wr_busy_r && wr_beat_r == 2'h2) begin
      beat_fire = 1'b1;
    end else if (kn_rise && wr_busy_r && wr_beat_r[0]) begin
      beat_fire = 1'b1;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_busy_r <= 1'b0;
      wr_beat_r <= 2'h0;
      pend_v_r <= 1'b0;
      pend_a_r <= 20'h00000;
      wr_a_r <= 20'h00000;
    end else begin
      if (beat_fire) begin
        wr_a_r <= beat_addr;
        wr_beat_r <= beat_idx + 2'h1;
        wr_busy_r <= (beat_idx != 2'h3);
      end
      if (k_rise && !pin_r[`PIN_WSEL]) begin
        pend_v_r <= 1'b1;
        pend_a_r <= addr_eff;
      end else if (start_burst) begin
        pend_v_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Beat formation: data placed in its lane, mask from the sampled lane and nibble masks
  reg [35:0] bw_data;
  reg [35:0] bw_mask;
  reg [8:0] lane_m;
  reg [35:0] narrow_m;
  wire [1:0] bsub;
  wire [5:0] shift;

  assign bsub = sub_of(mode, beat_addr);
  assign shift = {1'b0, bsub, 3'h0} + {4'h0, bsub};

  always @* begin
    lane_m = {9{lane_en[0]}};
    bw_data = din;
    bw_mask = 36'h000000000;
    case (mode)
      `MODE_W36: begin
        bw_mask = {{9{lane_en[3]}}, {9{lane_en[2]}},
                   {9{lane_en[1]}}, {9{lane_en[0]}}};
      end
      `MODE_W18: begin
        bw_data = {din[17:0], din[17:0]};
        bw_mask = {18'h00000, {9{lane_en[1]}}, {9{lane_en[0]}}};
        if (bsub[1]) begin
          bw_mask = {bw_mask[17:0], 18'h00000};
        end
      end
      `MODE_W9: begin
        bw_data = {4{din[8:0]}};
        lane_m = {9{lane_en[0]}};
      end
      default: begin
        bw_data = {4{1'b0, din[7:0]}};
        lane_m = {1'b0, {4{nib_en[1]}}, {4{nib_en[0]}}};
      end
    endcase
    narrow_m = {27'h0000000, lane_m} << shift;
    if (mode == `MODE_W9 || mode == `MODE_W8) begin
      bw_mask = narrow_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Beat FIFO in front of the arrays; reads take priority at the arrays
  wire [`ENTRY_BITS-1:0] fifo_in;
  wire [`ENTRY_BITS-1:0] fifo_out;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire mem_wr_ready;
  wire [19:0] beat_word;
  reg rd_req_r;
  reg [17:0] rd_word_r;

  assign beat_word = word_of(mode, beat_addr);
  assign fifo_in = {beat_idx, beat_word[17:0], bw_data, bw_mask};
  assign mem_wr_ready = ~rd_req_r;

  sync_fifo #(
    .WIDTH(`ENTRY_BITS),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_ADDR_BITS)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(beat_fire),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(mem_wr_ready),
    .out_data(fifo_out)
  );

  wire [143:0] rd_data;

  sram_quad_array #(
    .AW(`ADDR_BITS_W36),
    .DW(`DATA_BITS)
  ) u_arrays (
    .clk(clk),
    .wr_en(fifo_out_valid & mem_wr_ready),
    .wr_bank(fifo_out[91:90]),
    .wr_addr(fifo_out[89:72]),
    .wr_data(fifo_out[71:36]),
    .wr_mask(fifo_out[35:0]),
    .rd_en(rd_req_r),
    .rd_addr(rd_word_r),
    .rd_data(rd_data)
  );

  // Beats arrive from pins and cannot be held off; a full FIFO drops them
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_stall <= 1'b0;
      write_overflow <= 1'b0;
    end else begin
      write_stall <= ~fifo_in_ready;
      if (beat_fire && !fifo_in_ready) begin
        write_overflow <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read bursts
  reg rd_busy_r;
  reg rd_have_r;
  reg [1:0] q_beat_r;
  reg [1:0] rd_sub_r;
  reg [1:0] rd_mode_r;
  reg q_done_r;
  reg q_fire;
  reg [35:0] q_word;
  reg [35:0] q_sel;
  wire [5:0] q_shift;
  wire [35:0] q_shifted;
  wire [19:0] rd_word_full;

  always @* begin
    q_fire = 1'b0;
    if (rd_have_r) begin
      if (!q_beat_r[0] && oc_rise) begin
        q_fire = 1'b1;
      end else if (q_beat_r[0] && ocn_rise) begin
        q_fire = 1'b1;
      end
    end
  end

  assign q_shift = {1'b0, rd_sub_r, 3'h0} + {4'h0, rd_sub_r};
  assign q_shifted = q_word >> q_shift;
  assign rd_word_full = word_of(mode, addr_eff);

  always @* begin
    q_word = rd_data[{q_beat_r, 5'h00} + {2'h0, q_beat_r, 2'h0} +: 36];
    case (rd_mode_r)
      `MODE_W36: q_sel = q_word;
      `MODE_W18: q_sel = {18'h00000, q_shifted[17:0]};
      `MODE_W9: q_sel = {27'h0000000, q_shifted[8:0]};
      default: q_sel = {28'h0000000, q_shifted[7:0]};
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_busy_r <= 1'b0;
      rd_have_r <= 1'b0;
      rd_req_r <= 1'b0;
      rd_word_r <= 18'h00000;
      rd_sub_r <= 2'h0;
      rd_mode_r <= `MODE_W8;
      q_beat_r <= 2'h0;
      q_done_r <= 1'b0;
      q_out <= 36'h000000000;
      q_oe <= 1'b0;
    end else begin
      rd_req_r <= 1'b0;
      if (rd_req_r) begin
        rd_have_r <= 1'b1;
      end
      if (k_rise && !pin_r[`PIN_RSEL] && !rd_busy_r) begin
        rd_busy_r <= 1'b1;
        rd_req_r <= 1'b1;
        rd_word_r <= rd_word_full[17:0];
        rd_sub_r <= sub_of(mode, addr_eff);
        rd_mode_r <= mode;
        q_beat_r <= 2'h0;
      end
      if (q_fire) begin
        q_out <= q_sel;
        q_oe <= 1'b1;
        q_beat_r <= q_beat_r + 2'h1;
        q_done_r <= 1'b0;
        if (q_beat_r == 2'h3) begin
          rd_busy_r <= 1'b0;
          rd_have_r <= 1'b0;
          q_done_r <= 1'b1;
        end
      end else if (q_done_r && oc_rise) begin
        q_oe <= 1'b0;
        q_done_r <= 1'b0;
      end
    end
  end

endmodule // sram_write_and_address_capture

/* File: core/sync_fifo.v */
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module sync_fifo #(
  parameter WIDTH = 92,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = store_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      store_r[wp_r] <= in_data;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule // sync_fifo

/* File: verif/mem_ctrl_model.sv */
// Controller model driving the SRAM clocks, selects, masks and data
`timescale 1ns/1ps
module mem_ctrl_model (
  input wire clk,
  output reg k_in,
  output reg k_n_in,
  output reg c_in,
  output reg c_n_in,
  output reg write_port_select_n,
  output reg read_port_select_n,
  output reg [3:0] mask_n,
  output reg [19:0] addr_in,
  output reg [35:0] data_in
);
  initial begin
    {k_in, k_n_in, c_in, c_n_in} = 4'h5;
    {write_port_select_n, read_port_select_n} = 2'h3;
    mask_n = 4'h0;
    addr_in = 20'h00000;
    data_in = 36'h000000000;
  end
  // Pins move mid half period: four clk of setup and of hold
  task step(input ws, input rs, input [3:0] mk, input [19:0] a,
    input [35:0] d);
    begin
      @(negedge clk);
      write_port_select_n = ws;
      read_port_select_n = rs;
      mask_n = mk;
      addr_in = a;
      data_in = d;
      repeat (4) @(negedge clk);
      {k_in, k_n_in, c_in, c_n_in} = ~{k_in, k_n_in, c_in, c_n_in};
      repeat (3) @(negedge clk);
    end
  endtask
  // Deselected edges carry inverted leftovers with masks asserted
  task idle;
    step(1'b1, 1'b1, 4'h0, ~addr_in, ~data_in);
  endtask
  task wr(input [19:0] a, input [143:0] d, input [15:0] mk);
    integer i;
    begin
      if (k_in) idle;
      step(1'b0, 1'b1, 4'h0, a, ~data_in);
      idle;
      for (i = 0; i < 4; i = i + 1)
        step(1'b1, 1'b1, mk[4*i+:4], ~addr_in, d[36*i+:36]);
    end
  endtask
  task rd(input [19:0] a);
    begin
      if (k_in) idle;
      step(1'b1, 1'b0, 4'h0, a, ~data_in);
      repeat (9) idle;
    end
  endtask
endmodule // mem_ctrl_model

/* File: verif/sram_cap_asserts.sv */
// Port assertions for the burst SRAM capture block
`timescale 1ns/1ps
`include "sram_map.vh"
module sram_cap_asserts (
  input wire clk,
  input wire sys_rst,
  input wire k_in,
  input wire k_n_in,
  input wire c_in,
  input wire c_n_in,
  input wire read_port_select_n,
  input wire [1:0] width_mode,
  input wire single_clock_mode,
  input wire [35:0] q_out,
  input wire q_oe,
  input wire write_stall,
  input wire write_overflow
);
  reg [3:0] pin_r;
  reg [6:0] rcnt_r;
  reg [2:0] oen_r;
  wire [3:0] rise = {c_n_in, c_in, k_n_in, k_in} & ~pin_r;
  // Output clock follows the input pair in single clock mode
  wire oclk = single_clock_mode ? |rise[1:0] : |rise[3:2];
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_r <= 4'hF;
      rcnt_r <= 7'h7F;
      oen_r <= 3'h0;
    end else begin
      pin_r <= {c_n_in, c_in, k_n_in, k_in};
      if (rise[0] && !read_port_select_n)
        rcnt_r <= 7'h00;
      else if (rcnt_r != 7'h7F)
        rcnt_r <= rcnt_r + 7'h01;
      oen_r <= !q_oe ? 3'h0 : oen_r + {2'h0, oclk};
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence oe_end;
    q_oe ##1 !q_oe;
  endsequence
  burst_four_a: assert property (oe_end |-> oen_r == 3'h4)
    else $error("read burst length wrong");
  oe_edges_a: assert property (q_oe |-> oen_r <= 3'h4)
    else $error("outputs driven past burst end");
  read_start_a: assert property ($rose(q_oe) |-> rcnt_r < 7'h28)
    else $error("outputs driven without read select");
  idle_float_a: assert property (rcnt_r > 7'h48 |-> !q_oe)
    else $error("outputs not released");
  narrow8_a: assert property (q_oe && width_mode == `MODE_W8
    |-> q_out[35:8] == 28'h0000000) else $error("8-bit upper set");
  narrow9_a: assert property (q_oe && width_mode == `MODE_W9
    |-> q_out[35:9] == 27'h0000000) else $error("9-bit upper set");
  overflow_keep_a: assert property ($past(write_overflow)
    |-> write_overflow) else $error("overflow flag cleared");
  reset_quiet_a: assert property ($past(sys_rst)
    |-> !q_oe && !write_stall && !write_overflow)
    else $error("outputs active after reset");
endmodule // sram_cap_asserts
bind sram_write_and_address_capture sram_cap_asserts chk_u (.clk(clk),
  .sys_rst(sys_rst), .k_in(k_in), .k_n_in(k_n_in), .c_in(c_in),
  .c_n_in(c_n_in), .read_port_select_n(read_port_select_n),
  .width_mode(width_mode), .single_clock_mode(single_clock_mode),
  .q_out(q_out), .q_oe(q_oe), .write_stall(write_stall),
  .write_overflow(write_overflow));

/* File: verif/sram_write_and_address_capture_bench.sv */
// Self-checking bench for the burst SRAM capture block
`timescale 1ns/1ps
`include "sram_map.vh"
`define CHK(g, e) begin \
  cmp_count = cmp_count + 1; \
  if ((g) !== (e)) begin \
    n_errors = n_errors + 1; \
    $display("Error t=%0t got %h exp %h", $time, g, e); \
  end \
end
module sram_write_and_address_capture_bench;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [1:0] width_mode = 2'h3;
  reg single_clock_mode = 1'b0;
  wire k_in, k_n_in, c_in, c_n_in, wsel_n, rsel_n, q_oe;
  wire write_stall, write_overflow;
  wire [3:0] mask_n;
  wire [19:0] addr_in;
  wire [35:0] data_in, q_out;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  reg [31:0] seed = 32'h00014396;
  reg [35:0] exp_q [$];
  // Expected words per mode, burst and beat
  reg [35:0] ref_m [0:31];
  reg [2:0] slot = 3'h0;
  reg [35:0] got_e;
  always #10 clk = ~clk;
  mem_ctrl_model ctrl_u (.clk(clk), .k_in(k_in), .k_n_in(k_n_in),
    .c_in(c_in), .c_n_in(c_n_in), .write_port_select_n(wsel_n),
    .read_port_select_n(rsel_n), .mask_n(mask_n), .addr_in(addr_in),
    .data_in(data_in));
  sram_write_and_address_capture dut_u (.clk(clk), .sys_rst(sys_rst),
    .k_in(k_in), .k_n_in(k_n_in), .c_in(c_in), .c_n_in(c_n_in),
    .write_port_select_n(wsel_n), .read_port_select_n(rsel_n),
    .nibble_mask_lo_n(mask_n[0]), .nibble_mask_hi_n(mask_n[1]),
    .lane_mask0_n(mask_n[0]), .lane_mask1_n(mask_n[1]),
    .lane_mask2_n(mask_n[2]), .lane_mask3_n(mask_n[3]),
    .addr_in(addr_in), .data_in(data_in), .width_mode(width_mode),
    .single_clock_mode(single_clock_mode), .q_out(q_out), .q_oe(q_oe),
    .write_stall(write_stall), .write_overflow(write_overflow));
  ////////////////////////////////////////
  function automatic [31:0] rnd(input dummy);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function automatic [35:0] lanes(input [1:0] m, input [3:0] mk);
    reg [35:0] e;
    begin
      e = {{9{~mk[3]}}, {9{~mk[2]}}, {9{~mk[1]}}, {9{~mk[0]}}};
      case (m)
        `MODE_W8: e = {28'h0000000, {4{~mk[1]}}, {4{~mk[0]}}};
        `MODE_W9: e = e & 36'h0000001FF;
        `MODE_W18: e = e & 36'h00003FFFF;
        default: e = e;
      endcase
      lanes = e;
    end
  endfunction
  function automatic [19:0] amask(input [1:0] m);
    amask = m == `MODE_W36 ? `ADDR_MASK_W36 :
      (m == `MODE_W18 ? `ADDR_MASK_W18 : `ADDR_MASK_W8);
  endfunction
  task wr_burst(input [19:0] a, input full);
    reg [143:0] d;
    reg [15:0] mk;
    reg [63:0] r;
    reg [35:0] e;
    reg [4:0] key;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        r = {rnd(0), rnd(0)};
        d[36*i+:36] = r[35:0];
        mk[4*i+:4] = full ? 4'h0 : r[39:36];
        e = lanes(width_mode, mk[4*i+:4]);
        key = {slot, i[1:0]};
        ref_m[key] = ((full ? 36'h0 : ref_m[key]) & ~e) | (r[35:0] & e);
      end
      ctrl_u.wr(a, d, mk);
    end
  endtask
  task rd_burst(input [19:0] a);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        exp_q.push_back(ref_m[{slot, i[1:0]}]);
      ctrl_u.rd(a);
    end
  endtask
  // Sample late in the half period, once the beat has landed
  always @(posedge c_in or posedge c_n_in) begin
    repeat (7) @(negedge clk);
    if (q_oe === 1'b1 && exp_q.size() == 0)
      `CHK(q_oe, 1'b0)
    else if (q_oe === 1'b1) begin
      got_e = exp_q.pop_front();
      `CHK(q_out, got_e)
    end
  end
  task test_done;
    begin
      if (n_errors == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      test_done;
    end
  end
  initial begin : main
    integer m, j;
    reg [19:0] a;
    reg [31:0] r32;
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge clk);
    for (m = 0; m < 4; m = m + 1) begin
      width_mode = m[1:0];
      single_clock_mode = m[0];
      repeat (3) ctrl_u.idle;
      for (j = 0; j < 2; j = j + 1) begin
        r32 = rnd(0);
        a = r32[19:0];
        slot = {m[1:0], j[0]};
        wr_burst(a, 1'b1);
        wr_burst(a, 1'b0);
        repeat (2) ctrl_u.idle;
        // Upper bits beyond the mode's address width must not matter
        rd_burst(a ^ ~amask(width_mode));
        repeat (4) ctrl_u.idle;
      end
    end
    repeat (6) ctrl_u.idle;
    `CHK(exp_q.size(), 0)
    `CHK({write_stall, write_overflow}, 2'h0)
    test_done;
  end
endmodule // sram_write_and_address_capture_bench
